// >>> inc/cog_consts.svh
// Register offsets, field positions and reset values of the clock output generator
// What this block does
// - Clock derives from 24 MHz oscillator only
// - Five-bit divide factor, 1 to 31
// - New factor applied after current period ends
// - Pin select routes clock to GPIO4/GPIO6
// - Enable gates waveform only, never pin routing
// - Disable finishes period, then rests at 0
// - Reference enable forces GPIO3 as clock input
// - Clear write resets divider, output 0 now
// - Clear bit reads back 1 while idle or in pass-through
// - Clear plus new factor applies factor immediately
// - Inversion is last stage, sets rest level
// - Inversion change acts at once, glitch possible
// - Duty-balance option equalises halves for odd factors
// - Factors 0 and 1 pass oscillator through
// - Balance off: low half one cycle shorter for odd factors
// - Balance on: two-edge combination, near 1:1
`ifndef COG_CONSTS_SVH
`define COG_CONSTS_SVH

`define COG_DIVSET_ADDR    8'h8F
`define COG_DIVSET_RESET   8'h00
`define COG_PORTSET_ADDR   8'hB6
`define COG_PORTSET_RESET  8'h00

`define COG_CLR_BIT        7
`define COG_INV_BIT        6
`define COG_SYM_BIT        5
`define COG_DIV_MSB        4
`define COG_DIV_LSB        0

`define COG_SEL4_BIT       4
`define COG_SEL6_BIT       5
`define COG_EN_BIT         3
`define COG_REFEN_BIT      2

`define COG_BYPASS_MAX     5'h01
`define COG_CNT_ONE        5'h01

`endif

// >>> inc/cog_pkg.sv
// Types shared by the clock output generator
package cog_pkg;

  typedef logic [7:0] cog_byte_t;
  typedef logic [4:0] cog_div_t;

  typedef enum logic [1:0]
  {
    COG_IDLE = 2'b00,
    COG_PASS = 2'b01,
    COG_LOW  = 2'b10,
    COG_HIGH = 2'b11
  } cog_phase_e;

endpackage

// >>> inc/cog_osc_if.sv
// Synchronised oscillator level and edge ticks
`timescale 1ns/1ns
`default_nettype none

interface cog_osc_if;
  logic level;
  logic rise;
  logic fall;

  modport src
  (
    output level,
    output rise,
    output fall
  );

  modport dst
  (
    input level,
    input rise,
    input fall
  );
endinterface

`default_nettype wire

// >>> core/cog_osc_sync.sv
// Oscillator pin synchroniser and edge detector
`timescale 1ns/1ns
`default_nettype none

module cog_osc_sync
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic oscClk,
  cog_osc_if.src    osc
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= oscClk;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign osc.level = sync_reg;
  assign osc.rise  = sync_reg & ~prev_reg;
  assign osc.fall  = ~sync_reg & prev_reg;
endmodule

`default_nettype wire

// >>> core/cog_clock_output_generator.sv
// Clock output generator: SFR pair, divider and pin routing
`timescale 1ns/1ns
`default_nettype none
`include "cog_consts.svh"

module cog_clock_output_generator
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              oscClk,
  input  wire logic              gpio3In,
  input  wire cog_pkg::cog_byte_t sfrAddr,
  input  wire logic              sfrWr,
  input  wire logic              sfrRd,
  input  wire cog_pkg::cog_byte_t sfrWdata,
  output var  cog_pkg::cog_byte_t sfrRdata,
  output var  logic              gpio4ClkSel,
  output var  logic              gpio4Clk,
  output var  logic              gpio6ClkSel,
  output var  logic              gpio6Clk,
  output var  logic              gpio3ForceInput,
  output var  logic              refClk
);
  import cog_pkg::*;

  cog_osc_if osc ();

  cog_byte_t  divSet_reg;
  cog_byte_t  portSet_reg;
  cog_phase_e phase_reg;
  cog_div_t   curDiv_reg;
  logic       curSym_reg;
  logic [4:0] halfCnt_reg;
  logic       genClk_reg;
  logic       refMeta_reg;
  logic       refSync_reg;
  logic       clkOut_next;
  logic       divWrite;
  logic       portWrite;
  logic       clrWrite;
  logic       tick;
  logic       enable;
  logic       idle;
  cog_div_t   newDiv;
  logic       newSym;

  // Half-period length in ticks; balanced mode counts both oscillator edges
  function automatic logic [4:0] halfLen
  (
    input cog_div_t f,
    input logic     sym,
    input logic     high
  );
    logic [4:0] lowPart;
    lowPart = f >> 1;
    if (sym)
      return f;
    else if (high)
      return f - lowPart;
    else
      return lowPart;
  endfunction

  cog_osc_sync u_osc_sync
  (
    .mclk   (mclk),
    .srst   (srst),
    .oscClk (oscClk),
    .osc    (osc)
  );

  assign divWrite  = sfrWr && (sfrAddr == `COG_DIVSET_ADDR);
  assign portWrite = sfrWr && (sfrAddr == `COG_PORTSET_ADDR);
  assign clrWrite  = divWrite && sfrWdata[`COG_CLR_BIT];
  assign enable    = portSet_reg[`COG_EN_BIT];
  assign newDiv    = divSet_reg[`COG_DIV_MSB:`COG_DIV_LSB];
  assign newSym    = divSet_reg[`COG_SYM_BIT];
  // Balanced mode uses both edges, i.e. the second flop's falling-edge timing
  assign tick      = curSym_reg ? (osc.rise | osc.fall) : osc.rise;
  assign idle      = (phase_reg != COG_LOW) && (phase_reg != COG_HIGH);

  // Clear is a strobe, so bit 7 is never stored
  always_ff @(posedge mclk)
  begin
    if (srst)
      divSet_reg <= `COG_DIVSET_RESET;
    else if (divWrite)
      divSet_reg <= {1'b0, sfrWdata[6:0]};
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      portSet_reg <= `COG_PORTSET_RESET;
    else if (portWrite)
      portSet_reg <= sfrWdata;
  end

  // Divider; setting changes are sampled on oscillator edges, except clear, which acts at once
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      phase_reg   <= COG_IDLE;
      curDiv_reg  <= 5'h00;
      curSym_reg  <= 1'b0;
      halfCnt_reg <= 5'h00;
      genClk_reg  <= 1'b0;
    end
    else if (clrWrite)
    begin
      // Next start reloads from the register, picking up a factor written alongside
      phase_reg   <= COG_IDLE;
      halfCnt_reg <= 5'h00;
      genClk_reg  <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        COG_IDLE:
        begin
          genClk_reg <= 1'b0;
          if (enable && osc.rise)
          begin
            curDiv_reg <= newDiv;
            curSym_reg <= newSym;
            if (newDiv <= `COG_BYPASS_MAX)
            begin
              phase_reg  <= COG_PASS;
              genClk_reg <= 1'b1;
            end
            else
            begin
              phase_reg   <= COG_LOW;
              halfCnt_reg <= `COG_CNT_ONE;
            end
          end
        end
        COG_PASS:
        begin
          genClk_reg <= osc.level;
          // Leave on an oscillator fall, once the high half of its period has finished; a clear write leaves at once
          if (osc.fall && (!enable || newDiv > `COG_BYPASS_MAX))
          begin
            phase_reg  <= COG_IDLE;
            genClk_reg <= 1'b0;
          end
        end
        COG_LOW:
        begin
          if (tick)
          begin
            if (halfCnt_reg == halfLen(curDiv_reg, curSym_reg, 1'b0))
            begin
              phase_reg   <= COG_HIGH;
              halfCnt_reg <= `COG_CNT_ONE;
              genClk_reg  <= 1'b1;
            end
            else
              halfCnt_reg <= halfCnt_reg + `COG_CNT_ONE;
          end
        end
        COG_HIGH:
        begin
          if (tick)
          begin
            if (halfCnt_reg == halfLen(curDiv_reg, curSym_reg, 1'b1))
            begin
              if (!enable)
              begin
                phase_reg  <= COG_IDLE;
                genClk_reg <= 1'b0;
              end
              else
              begin
                curDiv_reg <= newDiv;
                curSym_reg <= newSym;
                if (newDiv <= `COG_BYPASS_MAX)
                begin
                  phase_reg  <= COG_PASS;
                  genClk_reg <= 1'b1;
                end
                else
                begin
                  phase_reg   <= COG_LOW;
                  halfCnt_reg <= `COG_CNT_ONE;
                  genClk_reg  <= 1'b0;
                end
              end
            end
            else
              halfCnt_reg <= halfCnt_reg + `COG_CNT_ONE;
          end
        end
        default:
        begin
          phase_reg  <= COG_IDLE;
          genClk_reg <= 1'b0;
        end
      endcase
    end
  end

  // Inverter sits after the divider and is not synchronised to it, so
  // flipping it mid-period can emit a short pulse
  assign clkOut_next = genClk_reg ^ divSet_reg[`COG_INV_BIT];

  // Pin routing follows the select bits alone, independent of the enable
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      gpio4ClkSel <= 1'b0;
      gpio6ClkSel <= 1'b0;
      gpio4Clk    <= 1'b0;
      gpio6Clk    <= 1'b0;
    end
    else
    begin
      gpio4ClkSel <= portSet_reg[`COG_SEL4_BIT];
      gpio6ClkSel <= portSet_reg[`COG_SEL6_BIT];
      gpio4Clk    <= portSet_reg[`COG_SEL4_BIT] & clkOut_next;
      gpio6Clk    <= portSet_reg[`COG_SEL6_BIT] & clkOut_next;
    end
  end

  // Reference pin: forced input overrides port data and config downstream
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      refMeta_reg     <= 1'b0;
      refSync_reg     <= 1'b0;
      gpio3ForceInput <= 1'b0;
      refClk          <= 1'b0;
    end
    else
    begin
      refMeta_reg     <= gpio3In;
      refSync_reg     <= refMeta_reg;
      gpio3ForceInput <= portSet_reg[`COG_REFEN_BIT];
      refClk          <= portSet_reg[`COG_REFEN_BIT] & refSync_reg;
    end
  end

  // Read data lands one cycle after the read strobe and holds until the next read
  always_ff @(posedge mclk)
  begin
    if (srst)
      sfrRdata <= 8'h00;
    else if (sfrRd)
    begin
      case (sfrAddr)
        `COG_DIVSET_ADDR:  sfrRdata <= {idle, divSet_reg[6:0]};
        `COG_PORTSET_ADDR: sfrRdata <= portSet_reg;
        default:           sfrRdata <= 8'h00;
      endcase
    end
  end
endmodule

`default_nettype wire

// >>> test/cog_clock_output_generator_monitor.sv
// Port-level assertions for the clock output generator
`timescale 1ns/1ns
`default_nettype none

module cog_clock_output_generator_monitor
(
  input wire logic               mclk,
  input wire logic               srst,
  input wire cog_pkg::cog_byte_t sfrAddr,
  input wire logic               sfrWr,
  input wire logic               sfrRd,
  input wire cog_pkg::cog_byte_t sfrWdata,
  input wire cog_pkg::cog_byte_t sfrRdata,
  input wire logic               gpio4ClkSel,
  input wire logic               gpio4Clk,
  input wire logic               gpio6ClkSel,
  input wire logic               gpio3ForceInput,
  input wire logic               refClk
);
  import cog_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic       wDiv;
  logic       wPort;
  logic [6:0] divReg;
  cog_byte_t  portReg;
  assign wDiv = sfrWr && sfrAddr == 8'h8F;
  assign wPort = sfrWr && sfrAddr == 8'hB6;
  always_ff @(posedge mclk)
    if (srst)
      divReg <= 7'h00;
    else if (wDiv)
      divReg <= sfrWdata[6:0];
  always_ff @(posedge mclk)
    if (srst)
      portReg <= 8'h00;
    else if (wPort)
      portReg <= sfrWdata;
  // Factors of two and up start with a low half, so the pin stays low well past the clear
  sequence clrStart;
    wDiv && sfrWdata[7:6] == 2'b10 && sfrWdata[4:0] > 5'h01;
  endsequence
  sequence restLow;
    !gpio4Clk [*4];
  endsequence
  chk_clear_low: assert property (clrStart |-> ##2 restLow)
    else $error("pin not held low after clear");
  // Pin controls are registered from the stored setup byte, so they land two edges after a write
  chk_sel4_route: assert property (wPort |=> ##1 gpio4ClkSel == $past(sfrWdata[4], 2))
    else $error("gpio4 select wrong");
  chk_sel6_route: assert property (wPort |=> ##1 gpio6ClkSel == $past(sfrWdata[5], 2))
    else $error("gpio6 select wrong");
  chk_ref_force: assert property (wPort |=> ##1
    gpio3ForceInput == $past(sfrWdata[2], 2))
    else $error("gpio3 force wrong");
  chk_pin4_gate: assert property (!gpio4ClkSel && !$past(gpio4ClkSel) |-> !gpio4Clk)
    else $error("clock on unselected gpio4");
  chk_ref_gate: assert property (!gpio3ForceInput [*2] |-> !refClk)
    else $error("reference clock passed while off");
  chk_div_read: assert property (sfrRd && sfrAddr == 8'h8F |=>
    sfrRdata[6:0] == $past(divReg))
    else $error("divider setup readback wrong");
  chk_port_read: assert property (sfrRd && sfrAddr == 8'hB6 |=>
    sfrRdata == $past(portReg))
    else $error("port setup readback wrong");
endmodule

bind cog_clock_output_generator cog_clock_output_generator_monitor cog_mon_inst
(
  .mclk, .srst, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata,
  .gpio4ClkSel, .gpio4Clk, .gpio6ClkSel, .gpio3ForceInput, .refClk
);

`default_nettype wire

// >>> test/cog_clock_source.sv
// Oscillator and reference clock sources feeding the generator
`timescale 1ns/1ns
`default_nettype none

module cog_clock_source
(
  output var logic oscClk,
  output var logic refIn
);
  // 42 ns is the nearest whole-ns period to the oscillator rate
  initial oscClk = 1'b0;
  always #21 oscClk = !oscClk;
  initial refIn = 1'b0;
  always #33 refIn = !refIn;
endmodule

`default_nettype wire

// >>> test/cog_clock_output_generator_tb_top.sv
// Self-checking bench for the clock output generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errCount++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module cog_clock_output_generator_tb_top;
  import cog_pkg::*;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        oscClk;
  logic        gpio3In;
  cog_byte_t   sfrAddr = 8'h00;
  logic        sfrWr = 1'b0;
  logic        sfrRd = 1'b0;
  cog_byte_t   sfrWdata = 8'h00;
  cog_byte_t   sfrRdata;
  logic        gpio4ClkSel, gpio4Clk, gpio6ClkSel, gpio6Clk, gpio3ForceInput, refClk;
  int          errCount = 0;
  int          samplesChecked = 0;
  cog_byte_t   expQ[$];
  cog_byte_t   expV;
  logic        rdPend = 1'b0;
  logic [15:0] lfsr = 16'h058F;

  cog_clock_output_generator cog_clock_output_generator_inst
  (
    .mclk, .srst, .oscClk, .gpio3In, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata,
    .gpio4ClkSel, .gpio4Clk, .gpio6ClkSel, .gpio6Clk, .gpio3ForceInput, .refClk
  );
  cog_clock_source cog_clock_source_inst (.oscClk, .refIn(gpio3In));

  always #5 mclk = !mclk;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wr(input cog_byte_t a, input cog_byte_t d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWr <= 1'b1;
    @(posedge mclk);
    sfrWr <= 1'b0;
  endtask

  task automatic rd(input cog_byte_t a, input cog_byte_t e);
    expQ.push_back(e);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge mclk);
    sfrRd <= 1'b0;
  endtask

  // Edges are seen through a 100 MHz synchroniser, so results are rounded to oscillator cycles
  task automatic measure(input int d, input logic sym);
    time t0, t1, t2;
    int  hiMinusLo;
    repeat (2) @(posedge gpio4Clk);
    t0 = $time;
    @(negedge gpio4Clk);
    t1 = $time;
    @(posedge gpio4Clk);
    t2 = $time;
    hiMinusLo = int'(2 * t1 - t0 - t2);
    `CHK((t2 - t0 + 21) / 42, (d < 2) ? 1 : d)
    `CHK((hiMinusLo + 441) / 42 - 10, (sym || d < 2) ? 0 : d % 2)
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    if (rdPend && expQ.size() > 0)
    begin
      expV = expQ.pop_front();
      `CHK(sfrRdata, expV)
    end
    rdPend = sfrRd;
  end

  initial
  begin
    #200000;
    errCount++;
    endOfTest();
  end

  initial
  begin
    cog_div_t d;
    logic     sym;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h8F, 8'h80);
    rd(8'hB6, 8'h00);
    rd(8'h99, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      sym = lfsr[0];
      d = (i < 2) ? 5'(i) : (i == 2) ? 5'h1F : 5'(lfsr % 30 + 2);
      wr(8'h8F, {i[0], 1'b0, sym, d});
      if (i == 0)
        wr(8'hB6, 8'h38);
      measure(int'(d), sym);
      rd(8'h8F, {d < 5'h02, 1'b0, sym, d});
    end
    $display("test divide done");
    wr(8'hB6, 8'h30);
    // Longest period is 31 oscillator cycles, well under 200 clocks
    repeat (200) @(posedge mclk);
    rd(8'h8F, {1'b1, 1'b0, sym, d});
    `CHK(gpio4Clk, 1'b0)
    `CHK(gpio4ClkSel, 1'b1)
    wr(8'h8F, {2'b01, sym, d});
    repeat (3) @(posedge mclk);
    `CHK({gpio4Clk, gpio6Clk}, 2'b11)
    $display("test stop level done");
    wr(8'hB6, 8'h24);
    @(posedge refClk);
    // The pin controls may switch on the very edge that raises refClk, so look one edge later
    @(posedge mclk);
    `CHK({gpio4ClkSel, gpio4Clk, gpio6Clk, gpio3ForceInput}, 4'h3)
    rd(8'hB6, 8'h24);
    repeat (3) @(posedge mclk);
    $display("test routing done");
    endOfTest();
  end
endmodule

`default_nettype wire
